//--- acc_chan_decode.sv
// Channel selector decode to an analog mux one-hot select.
// Assumes the analog mux treats an all-zero select as isolated.
`timescale 1ns/1ps
`default_nettype none
module acc_chan_decode (
	input wire logic [4:0] chan, // Channel select code
	output logic [12:0] mux_sel, // 0..9 inputs, 10 bandgap, 11 high, 12 low ref
	output logic chan_valid // Code maps to a real source
);
	// Map codes to sources; unused codes select nothing
	always_comb begin
		mux_sel = 13'h0000;
		if (chan[4:3] == 2'h0) begin
			mux_sel[chan[2:0]] = 1'b1;
		end else if (chan == 5'h18) begin
			mux_sel[8] = 1'b1;
		end else if (chan == 5'h19) begin
			mux_sel[9] = 1'b1;
		end else if (chan == acc_pkg::CHAN_BANDGAP) begin
			mux_sel[10] = 1'b1;
		end else if (chan == acc_pkg::CHAN_VREFH) begin
			mux_sel[11] = 1'b1;
		end else if (chan == acc_pkg::CHAN_VREFL) begin
			mux_sel[12] = 1'b1;
		end
		chan_valid = |mux_sel;
	end
endmodule // acc_chan_decode
`default_nettype wire

//--- acc_conv_ctrl.sv
// Converter control: status/control, results, clock config, AXI4-Lite slave.
// Assumes the analog core samples while conv_active and returns conv_data.
// Operation
// - With break-clear disabled, break-time accesses leave status bits alone.
// - Two-step clear started before break holds in break, finishes after.
// - No hardware trigger; conversions start only from register writes.
// - Status/control write aborts conversion, restarts unless channel all ones.
// - Done flag read-only; set at end, cleared by control write or low read.
// - Interrupt asserts at end if enabled; drops on low result read or control write.
// - Continuous mode converts back to back, updating results each time.
// - Continuous ends on reset, stop entry without async clock, clock write, control write.
// - After stop abort, resume only on a new control write.
// - Control write with continuous and valid channel starts continuous.
// - Single mode: one conversion per control write with valid channel.
// - Five-bit channel field selects inputs, references, or off.
// - All ones turns off, isolates pad, no trailing single conversion.
// - Low-power state entered automatically when nothing is pending.
// - Unused channel codes give undefined results.
// - In 10-bit mode high read blocks updates until low read.
// - Stop entry without async clock aborts; results keep last value.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl #(
	parameter int SHORT_CYCLES = acc_pkg::CONV_SHORT_CYCLES,
	parameter int LONG_CYCLES = acc_pkg::CONV_LONG_CYCLES
) (
	input wire logic aclk, // Bus clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic break_active, // System in break state
	input wire logic stop_entry, // Pulse: entering stop mode
	input wire logic [9:0] conv_data, // Raw result from the analog core
	output logic conv_active, // Analog core sampling/converting
	output logic conv_powered, // Converter out of low-power state
	output logic [12:0] mux_sel, // One-hot analog source select
	output logic conv_irq // Conversion complete interrupt
);
	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_CONV = 3'b010,
		ACC_DONE = 3'b100
	} acc_state_t;

	acc_state_t state_reg;
	logic [4:0] chan_reg;
	logic cont_reg, irq_en_reg, done_reg, hold_reg, break_clear_enable_reg;
	logic [7:0] clk_cfg_reg;
	logic [15:0] cnt_reg;
	logic [9:0] result_reg;
	logic aw_got_reg, w_got_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire, rd_fire, wr_csc, wr_clk, wr_sys, rd_low, rd_high;
	logic status_ok, chan_valid, mode10, conv_end, start_conv;
	logic [15:0] conv_len;

	// Word select shared by both channels
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		return a[7:2] == reg_addr[7:2];
	endfunction

	// Write channel: accept address and data in either order
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (wr_fire) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end
	assign wr_fire = aw_got_reg && w_got_reg;
	// Only lane 0 carries the 8-bit registers
	assign wr_csc = wr_fire && w_strb_reg[0] && hit(aw_addr_reg, acc_pkg::ADDR_STATUS_CONTROL);
	assign wr_clk = wr_fire && w_strb_reg[0] && hit(aw_addr_reg, acc_pkg::ADDR_CLOCK_CFG);
	assign wr_sys = wr_fire && w_strb_reg[0] && hit(aw_addr_reg, acc_pkg::ADDR_SYS_CTRL);

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= acc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (hit(aw_addr_reg, acc_pkg::ADDR_STATUS_CONTROL) ||
				hit(aw_addr_reg, acc_pkg::ADDR_CLOCK_CFG) ||
				hit(aw_addr_reg, acc_pkg::ADDR_SYS_CTRL) ||
				hit(aw_addr_reg, acc_pkg::ADDR_RESULT_HIGH) ||
				hit(aw_addr_reg, acc_pkg::ADDR_RESULT_LOW)) ?
				acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one-cycle answer from registered data
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_low = rd_fire && hit(s_axi_araddr, acc_pkg::ADDR_RESULT_LOW);
	assign rd_high = rd_fire && hit(s_axi_araddr, acc_pkg::ADDR_RESULT_HIGH);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= acc_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= acc_pkg::RESP_OKAY;
			case (s_axi_araddr[7:2])
				acc_pkg::ADDR_STATUS_CONTROL[7:2]: s_axi_rdata <= {24'h000000, done_reg,
					irq_en_reg, cont_reg, chan_reg};
				acc_pkg::ADDR_RESULT_HIGH[7:2]: s_axi_rdata <= {30'h0, mode10 ? result_reg[9:8] : 2'h0};
				acc_pkg::ADDR_RESULT_LOW[7:2]: s_axi_rdata <= {24'h000000, result_reg[7:0]};
				acc_pkg::ADDR_CLOCK_CFG[7:2]: s_axi_rdata <= {24'h000000, clk_cfg_reg};
				acc_pkg::ADDR_SYS_CTRL[7:2]: s_axi_rdata <= {31'h0, break_clear_enable_reg};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= acc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// status gate: break protects flags unless break-clear enabled
	assign status_ok = !break_active || break_clear_enable_reg;
	assign mode10 = clk_cfg_reg[acc_pkg::CLK_MODE_LSB +: 2] == acc_pkg::MODE_10BIT;

	// Break-clear enable and clock config registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			break_clear_enable_reg <= 1'b0;
			clk_cfg_reg <= acc_pkg::CLK_RESET;
		end else begin
			if (wr_sys) begin
				break_clear_enable_reg <= w_data_reg[acc_pkg::SYS_BREAK_CLEAR_BIT];
			end
			if (wr_clk) begin
				clk_cfg_reg <= w_data_reg[7:0];
			end
		end
	end

	// Status/control fields written by software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_reg <= acc_pkg::CSC_RESET[4:0];
			cont_reg <= acc_pkg::CSC_RESET[acc_pkg::CSC_CONT_BIT];
			irq_en_reg <= acc_pkg::CSC_RESET[acc_pkg::CSC_IRQ_EN_BIT];
		end else if (wr_csc) begin
			chan_reg <= w_data_reg[acc_pkg::CSC_CHAN_LSB +: acc_pkg::CHAN_W];
			cont_reg <= w_data_reg[acc_pkg::CSC_CONT_BIT];
			irq_en_reg <= w_data_reg[acc_pkg::CSC_IRQ_EN_BIT];
		end
	end

	// source decode; unused codes select nothing
	acc_chan_decode u_decode (
		.chan(chan_reg),
		.mux_sel(mux_sel),
		.chan_valid(chan_valid)
	);

	// starts come only from control writes with channel not off
	assign start_conv = wr_csc &&
		(w_data_reg[acc_pkg::CSC_CHAN_LSB +: acc_pkg::CHAN_W] != acc_pkg::CHAN_OFF);
	assign conv_len = clk_cfg_reg[acc_pkg::CLK_LSMP_BIT] ? 16'(LONG_CYCLES) : 16'(SHORT_CYCLES);
	assign conv_end = (state_reg == ACC_CONV) && (cnt_reg == 16'h0001);

	// Conversion sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ACC_IDLE;
			cnt_reg <= 16'h0000;
		end else if (wr_csc) begin
			// abort and restart; off code stops with nothing trailing
			state_reg <= start_conv ? ACC_CONV : ACC_IDLE;
			cnt_reg <= conv_len;
		end else if (wr_clk || (stop_entry && !clk_cfg_reg[acc_pkg::CLK_ASYNC_EN_BIT])) begin
			// abort; only a fresh control write restarts
			state_reg <= ACC_IDLE;
			cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ACC_IDLE: state_reg <= ACC_IDLE;
				ACC_CONV: begin
					cnt_reg <= cnt_reg - 16'h0001;
					if (conv_end) begin
						state_reg <= ACC_DONE;
					end
				end
				ACC_DONE: begin
					// back to back in continuous; else drop to low power
					if (cont_reg && chan_reg != acc_pkg::CHAN_OFF) begin
						state_reg <= ACC_CONV;
						cnt_reg <= conv_len;
					end else begin
						state_reg <= ACC_IDLE;
					end
				end
				default: state_reg <= ACC_IDLE;
			endcase
		end
	end
	assign conv_active = state_reg == ACC_CONV;
	assign conv_powered = state_reg != ACC_IDLE;

	// Result and high-read interlock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_reg <= 10'h000;
			hold_reg <= 1'b0;
		end else begin
			// result loads with the done flag; blocked while held
			if (conv_end && !hold_reg) begin
				result_reg <= mode10 ? conv_data : {2'h0, conv_data[9:2]};
			end
			// high read arms, low read releases; break freezes it unless break-clear enabled
			if (rd_low && status_ok) begin
				hold_reg <= 1'b0;
			end else if (rd_high && mode10 && status_ok) begin
				hold_reg <= 1'b1;
			end else if (!mode10) begin
				hold_reg <= 1'b0;
			end
		end
	end

	// done flag: set wins over clear; clears gated in break
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_reg <= 1'b0;
		end else if (conv_end && !hold_reg) begin
			done_reg <= 1'b1;
		end else if ((wr_csc || rd_low) && status_ok) begin
			done_reg <= 1'b0;
		end
	end
	assign conv_irq = done_reg && irq_en_reg;
endmodule // acc_conv_ctrl
`default_nettype wire

//--- acc_conv_ctrl_assertions.sv
// Checker for the converter control block, fed from its top ports.
// Assumes one clock domain and a bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_assertions #(
	parameter int SHORT_CYCLES = 20,
	parameter int LONG_CYCLES = 40
) (
	input wire logic aclk, // Bus clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic conv_active, // Converting
	input wire logic conv_powered, // Out of low power
	input wire logic [12:0] mux_sel, // Source select
	input wire logic conv_irq // Interrupt
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles spent converting so far; cleared in idle
	logic [7:0] run_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || !conv_active) begin
			run_cnt <= 8'h00;
		end else if ($rose(s_axi_bvalid)) begin
			// A control write restarts with no idle cycle between
			run_cnt <= 8'h01;
		end else begin
			run_cnt <= run_cnt + 8'h01;
		end
	end
	// Converting, one idle cycle, converting again
	sequence s_restart;
		conv_active ##1 !conv_active ##1 conv_active;
	endsequence
	// Restart without a write must follow a full-length conversion
	property p_restart;
		s_restart ##0 (!s_axi_bvalid && !$past(s_axi_bvalid)) |->
			($past(run_cnt, 2) == SHORT_CYCLES - 1) || ($past(run_cnt, 2) == LONG_CYCLES - 1);
	endproperty
	chk_gap_restart: assert property (p_restart)
		else $error("continuous restart after wrong length");
	chk_run_bound: assert property (conv_active && !$rose(s_axi_bvalid) |-> run_cnt < LONG_CYCLES)
		else $error("conversion runs too long");
	chk_mux_onehot: assert property ($onehot0(mux_sel))
		else $error("more than one source selected");
	chk_start_cause: assert property ($rose(conv_active) |-> $rose(s_axi_bvalid) || $past(conv_active, 2))
		else $error("conversion started without a write");
	chk_irq_end: assert property ($rose(conv_irq) |-> $past(conv_active))
		else $error("interrupt rose outside a conversion end");
	chk_active_power: assert property (conv_active |-> conv_powered)
		else $error("converting while powered down");
	chk_reset_idle: assert property ($rose(aresetn) |-> !conv_active && !conv_powered && !conv_irq && mux_sel == 13'h0000)
		else $error("not idle after reset");
	chk_done_brief: assert property (conv_powered && !conv_active |=> !conv_powered || conv_active)
		else $error("converter stayed powered after a conversion");
	chk_irq_drop: assert property ($fell(conv_irq) |-> $rose(s_axi_bvalid) || $rose(s_axi_rvalid))
		else $error("interrupt dropped without a register access");
endmodule // acc_conv_ctrl_assertions
bind acc_conv_ctrl acc_conv_ctrl_assertions #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .conv_active(conv_active),
	.conv_powered(conv_powered), .mux_sel(mux_sel), .conv_irq(conv_irq));
`default_nettype wire

//--- acc_conv_ctrl_tb.sv
// Bench for the converter control block, one task per scenario.
// Assumes the core model on the analog side and short lengths.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, brk = 1'b0, stop = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, active, powered, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [9:0] cdata;
	logic [12:0] mux;
	int failures = 0;
	int n_tests = 0;
	acc_conv_ctrl #(.SHORT_CYCLES(6), .LONG_CYCLES(10)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.break_active(brk), .stop_entry(stop), .conv_data(cdata), .conv_active(active),
		.conv_powered(powered), .mux_sel(mux), .conv_irq(irq));
	acc_core_model core (.aclk(aclk), .conv_active(active), .mux_sel(mux), .conv_data(cdata));
	task automatic close_out();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic hang();
		failures++;
		close_out();
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		logic ta, tw;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			if (bvalid === 1'b1) begin
				chk({30'h0, bresp}, {30'h0, e});
				@(posedge aclk);
				return;
			end
			@(posedge aclk);
			if (ta === 1'b1) awvalid <= 1'b0;
			if (tw === 1'b1) wvalid <= 1'b0;
		end
		hang();
	endtask
	// Read with expected byte and response
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
		logic ta;
		araddr <= a;
		arvalid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = arready;
			if (rvalid === 1'b1) begin
				chk(rdata, {24'h000000, e});
				chk({30'h0, rresp}, {30'h0, r});
				@(posedge aclk);
				return;
			end
			@(posedge aclk);
			if (ta === 1'b1) arvalid <= 1'b0;
		end
		hang();
	endtask
	// Wait for interrupt (sel 0) or activity (sel 1) to reach v
	task automatic wt(input logic sel, input logic v);
		for (int n = 0; n < 200; n++) begin
			@(negedge aclk);
			if ((sel ? active : irq) === v) begin
				@(posedge aclk);
				return;
			end
		end
		hang();
	endtask
	// No conversion may run for cyc cycles
	task automatic quiet(input int cyc);
		logic seen;
		seen = 1'b0;
		repeat (cyc) begin
			@(negedge aclk);
			seen = seen | active;
		end
		chk({31'h0, seen}, 32'h0);
		@(posedge aclk);
	endtask
	task automatic t_regs();
		rd(8'h00, 8'h1F, 2'h0);
		rd(8'h0C, 8'h00, 2'h0);
		rd(8'h10, 8'h00, 2'h0);
		rd(8'h14, 8'h00, 2'h2);
		wr(8'h14, 8'hFF, 2'h2);
	endtask
	task automatic t_chan();
		logic [4:0] codes [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
			5'h07, 5'h18, 5'h19, 5'h1A, 5'h1D, 5'h1E};
		for (int i = 0; i < 13; i++) begin
			wr(8'h00, {3'h0, codes[i]}, 2'h0);
			chk({19'h0, mux}, 32'h1 << i);
		end
		wr(8'h00, 8'h1F, 2'h0);
		chk({19'h0, mux}, 32'h0);
	endtask
	task automatic t_single();
		wr(8'h00, 8'h43, 2'h0);
		wt(1'b0, 1'b1);
		rd(8'h00, 8'hC3, 2'h0);
		rd(8'h04, 8'h00, 2'h0);
		rd(8'h08, 8'h57, 2'h0);
		chk({31'h0, irq}, 32'h0);
		rd(8'h00, 8'h43, 2'h0);
		quiet(20);
		chk({31'h0, powered}, 32'h0);
	endtask
	task automatic t_cont();
		int starts;
		logic prev;
		starts = 0;
		prev = 1'b1;
		wr(8'h00, 8'h25, 2'h0);
		repeat (40) begin
			@(negedge aclk);
			if (active === 1'b1 && !prev) starts++;
			prev = active;
		end
		@(posedge aclk);
		chk({31'h0, starts >= 4}, 32'h1);
		rd(8'h08, 8'h5D, 2'h0);
		wr(8'h00, 8'h3F, 2'h0);
		quiet(30);
		chk({19'h0, mux}, 32'h0);
	endtask
	task automatic t_stop();
		wr(8'h00, 8'h23, 2'h0);
		stop <= 1'b1;
		@(posedge aclk);
		stop <= 1'b0;
		quiet(30);
		rd(8'h08, 8'h5D, 2'h0);
		wr(8'h00, 8'h25, 2'h0);
		wr(8'h0C, 8'h00, 2'h0);
		quiet(30);
	endtask
	task automatic t_lock();
		wr(8'h0C, 8'h14, 2'h0);
		wr(8'h00, 8'h03, 2'h0);
		wt(1'b1, 1'b0);
		rd(8'h04, 8'h01, 2'h0);
		wr(8'h00, 8'h05, 2'h0);
		wt(1'b1, 1'b0);
		rd(8'h08, 8'h5D, 2'h0);
		rd(8'h00, 8'h05, 2'h0);
		wr(8'h0C, 8'h00, 2'h0);
	endtask
	task automatic t_break();
		wr(8'h00, 8'h03, 2'h0);
		wt(1'b1, 1'b0);
		brk <= 1'b1;
		rd(8'h08, 8'h57, 2'h0);
		rd(8'h00, 8'h83, 2'h0);
		brk <= 1'b0;
		rd(8'h08, 8'h57, 2'h0);
		rd(8'h00, 8'h03, 2'h0);
		wr(8'h10, 8'h01, 2'h0);
		wr(8'h00, 8'h03, 2'h0);
		wt(1'b1, 1'b0);
		brk <= 1'b1;
		rd(8'h08, 8'h57, 2'h0);
		brk <= 1'b0;
		rd(8'h00, 8'h03, 2'h0);
	endtask
	// Free-running bus clock
	initial begin
		forever #2 aclk = ~aclk;
	end
	// Reset, then every scenario in turn
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_chan();
		t_single();
		t_cont();
		t_stop();
		t_lock();
		t_break();
		close_out();
	end
endmodule // acc_conv_ctrl_tb
`default_nettype wire

//--- acc_core_model.sv
// Analog core stand-in: returns a code per selected source.
// Assumes the core runs on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
	input wire logic aclk, // Bus clock
	input wire logic conv_active, // Converting
	input wire logic [12:0] mux_sel, // Source select
	output logic [9:0] conv_data // Result code
);
	// bus clock equals core clock
	// Idle output toggles so stale data never looks valid
	always_ff @(posedge aclk) begin
		if (conv_active) conv_data <= mux_sel[9:0] ^ 10'h155;
		else conv_data <= ~conv_data;
	end
endmodule // acc_core_model
`default_nettype wire

//--- acc_pkg.sv
// Package for the converter control block: register map, fields, timing.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package acc_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
	localparam logic [7:0] ADDR_CLOCK_CFG = 8'h0C;
	localparam logic [7:0] ADDR_SYS_CTRL = 8'h10;
	// Status/control fields
	localparam int CSC_DONE_BIT = 7;
	localparam int CSC_IRQ_EN_BIT = 6;
	localparam int CSC_CONT_BIT = 5;
	localparam int CSC_CHAN_LSB = 0;
	localparam int CHAN_W = 5;
	// Clock register fields
	localparam int CLK_MODE_LSB = 2;
	localparam int CLK_LSMP_BIT = 4;
	localparam int CLK_ASYNC_EN_BIT = 0;
	localparam logic [1:0] MODE_8BIT = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h1;
	// System control fields
	localparam int SYS_BREAK_CLEAR_BIT = 0;
	// Reset values
	localparam logic [7:0] CSC_RESET = 8'h1F;
	localparam logic [7:0] CLK_RESET = 8'h00;
	// Channel codes
	localparam logic [4:0] CHAN_OFF = 5'h1F;
	localparam logic [4:0] CHAN_BANDGAP = 5'h1A;
	localparam logic [4:0] CHAN_VREFH = 5'h1D;
	localparam logic [4:0] CHAN_VREFL = 5'h1E;
	// Conversion length in bus clocks
	localparam int CONV_SHORT_CYCLES = 20;
	localparam int CONV_LONG_CYCLES = 40;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : acc_pkg
